// *** lil_blinker.sv ***
// Purpose: free-running blink phase for the flashing colours
// Assumes: clk_sys, synchronous active-low reset, clock enable freezes it
// Notes: phase toggles every half_cyc enabled cycles
`timescale 1ns/1ns
module lil_blinker #(
    parameter int HALF_CYC = lil_pkg::BLINK_HALF_CYC
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic ce,
    output logic phase
);

    localparam logic [lil_pkg::BLINK_W-1:0] LAST = lil_pkg::BLINK_W'(HALF_CYC - 1);

    logic [lil_pkg::BLINK_W-1:0] cnt;

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            cnt <= '0;
            phase <= 1'b0;
        end
        else if (ce)
        begin
            if (cnt >= LAST)
            begin
                cnt <= '0;
                phase <= ~phase;
            end
            else
            begin
                cnt <= cnt + 1'b1;
            end
        end
    end

endmodule

// *** lil_checker.sv ***
// Purpose: port-level checks for the indicator led block
// Assumes: one clock domain, ce dropped by the bench only while the bus is idle
// Notes: the settings are not visible here, so the led checks stay generic
`timescale 1ns/1ns
module lil_checker (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [lil_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [lil_pkg::DAT_W-1:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic led_red,
    input wire logic led_green
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sequence req_s;
        ce && wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence pulse_s;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    ack_latency_a: assert property (req_s |=> pulse_s)
        else $error("request not answered by a one-cycle ack");
    ack_unasked_a: assert property (ce && !wb_stb_i |=> !wb_ack_o)
        else $error("ack without a request");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
        else $error("ack not preceded by a request");
    read_idle_a: assert property (!wb_ack_o |-> wb_dat_o == '0)
        else $error("read data not zero outside ack");
    ctrl_upper_a: assert property (wb_ack_o && !$past(wb_we_i)
        && $past(wb_adr_i) == lil_pkg::ADR_CTRL |-> wb_dat_o[31:12] == '0)
        else $error("unused control bits read nonzero");
    led_colour_a: assert property (!(led_red && led_green))
        else $error("both led colours driven");
    reset_dark_a: assert property (@(posedge clk_sys) disable iff (1'b0)
        !reset_n |=> !led_red && !led_green)
        else $error("led lit after reset");
endmodule

bind lil_indicator lil_checker u_chk (.clk_sys, .reset_n, .ce, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .led_red, .led_green);

// *** lil_indicator.sv ***
// Purpose: one configurable bicolour indicator led with optional latch
// Assumes: source signals come from logic on clk_sys, so they are not synchronised
// Notes: classic wishbone; ack one cycle after the request is seen, writes land with the ack
`timescale 1ns/1ns

module lil_indicator #(
    parameter int BLINK_HALF_CYC = lil_pkg::BLINK_HALF_CYC
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic [lil_pkg::SRC_W-1:0] src_in,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [lil_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [lil_pkg::SEL_W-1:0] wb_sel_i,
    input wire logic [lil_pkg::DAT_W-1:0] wb_dat_i,
    output logic [lil_pkg::DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    output logic led_red,
    output logic led_green
);

    lil_pkg::lil_ctrl_t ctrl;
    lil_pkg::lil_sel_t [lil_pkg::NUM_IN-1:0] route;
    lil_pkg::lil_sel_t ack_sel;
    logic latched;
    logic phase;
    logic or_now;
    logic ack_now;
    logic shown;
    logic [1:0] next_drive;
    logic req;
    logic wr;
    logic hit_ctrl;
    logic hit_route;
    logic hit_acksel;
    lil_pkg::lil_status_t status;
    logic [lil_pkg::DAT_W-1:0] next_rdata;
    logic [lil_pkg::DAT_W-1:0] ctrl_word;
    logic [lil_pkg::DAT_W-1:0] route_word;
    logic [lil_pkg::DAT_W-1:0] acksel_word;
    logic [lil_pkg::DAT_W-1:0] merged;

    lil_blinker #(
        .HALF_CYC(BLINK_HALF_CYC)
    ) u_blink (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .ce(ce),
        .phase(phase)
    );

    // source combine and indication
    always_comb
    begin
        or_now = 1'b0;
        for (int i = 0; i < lil_pkg::NUM_IN; i++)
        begin
            or_now = or_now | (lil_pkg::lil_pick(src_in, route[i]) ^ ctrl.invert[i]);
        end
        ack_now = ctrl.latch_en & lil_pkg::lil_pick(src_in, ack_sel);
        shown = or_now | (ctrl.latch_en & latched);
        if (shown)
        begin
            next_drive = lil_pkg::lil_drive(ctrl.act, phase);
        end
        else
        begin
            next_drive = lil_pkg::lil_drive(ctrl.inact, phase);
        end
    end

    // latch: set cannot lose to ack, since ack only clears with the or false
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            latched <= 1'b0;
        end
        else if (ce)
        begin
            if (!ctrl.latch_en)
            begin
                latched <= 1'b0;
            end
            else if (or_now)
            begin
                latched <= 1'b1;
            end
            else if (ack_now)
            begin
                latched <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            led_red <= 1'b0;
            led_green <= 1'b0;
        end
        else if (ce)
        begin
            led_red <= next_drive[1];
            led_green <= next_drive[0];
        end
    end

    // register bus
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // a write lands at the edge where the master sees ack and never earlier,
    // so a request dropped before its ack leaves the settings untouched
    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
    assign hit_ctrl = wb_adr_i == lil_pkg::ADR_CTRL;
    assign hit_route = wb_adr_i == lil_pkg::ADR_ROUTE;
    assign hit_acksel = wb_adr_i == lil_pkg::ADR_ACKSEL;

    assign ctrl_word = {{(lil_pkg::DAT_W - lil_pkg::CTRL_W){1'b0}}, ctrl};
    assign route_word = {{(lil_pkg::DAT_W - lil_pkg::ROUTE_W){1'b0}}, route};
    assign acksel_word = {{(lil_pkg::DAT_W - lil_pkg::PICK_W){1'b0}}, ack_sel};

    always_comb
    begin
        status.red = led_red;
        status.green = led_green;
        status.latched = latched;
        status.or_state = or_now;
        case (wb_adr_i)
            lil_pkg::ADR_CTRL: next_rdata = ctrl_word;
            lil_pkg::ADR_ROUTE: next_rdata = route_word;
            lil_pkg::ADR_ACKSEL: next_rdata = acksel_word;
            lil_pkg::ADR_STATUS:
                next_rdata = {{(lil_pkg::DAT_W - lil_pkg::STAT_W){1'b0}}, status};
            default: next_rdata = '0;
        endcase
    end

    // only a writable word is merged; other addresses yield zero and are not stored
    always_comb
    begin
        case (wb_adr_i)
            lil_pkg::ADR_CTRL: merged = lil_pkg::lil_merge(ctrl_word, wb_dat_i, wb_sel_i);
            lil_pkg::ADR_ROUTE: merged = lil_pkg::lil_merge(route_word, wb_dat_i, wb_sel_i);
            lil_pkg::ADR_ACKSEL: merged = lil_pkg::lil_merge(acksel_word, wb_dat_i, wb_sel_i);
            default: merged = '0;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            wb_ack_o <= 1'b0;
        end
        else if (ce)
        begin
            wb_ack_o <= req;
        end
    end

    // read data stands only in the ack cycle and is zero otherwise
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            wb_dat_o <= '0;
        end
        else if (ce)
        begin
            wb_dat_o <= req ? next_rdata : '0;
        end
    end

    // unmapped writes and the read-only status word are acked and dropped
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            ctrl <= lil_pkg::CTRL_RST;
        end
        else if (ce && wr && hit_ctrl)
        begin
            ctrl <= lil_pkg::lil_ctrl_t'(merged[lil_pkg::CTRL_W-1:0]);
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            route <= lil_pkg::ROUTE_RST;
        end
        else if (ce && wr && hit_route)
        begin
            route <= merged[lil_pkg::ROUTE_W-1:0];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            ack_sel <= lil_pkg::PICK_RST;
        end
        else if (ce && wr && hit_acksel)
        begin
            ack_sel <= lil_pkg::lil_sel_t'(merged[lil_pkg::PICK_W-1:0]);
        end
    end

endmodule

// *** lil_pkg.sv ***
// Purpose: shared constants, types and helpers for the indicator led logic
// Assumes: 25 MHz system clock, 32-bit classic wishbone register access
// Notes: colour codes follow the order green, red, red flash, green flash, dark
package lil_pkg;

    localparam int CLK_HZ = 25_000_000;
    localparam int BLINK_HALF_MS = 250;
    localparam int BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;
    localparam int BLINK_W = 23;

    localparam int NUM_IN = 5;
    localparam int SRC_W = 16;
    localparam int IDX_W = 4;
    localparam int DAT_W = 32;
    localparam int ADR_W = 8;
    localparam int SEL_W = 4;

    localparam logic [ADR_W-1:0] ADR_CTRL = 8'h00;
    localparam logic [ADR_W-1:0] ADR_ROUTE = 8'h04;
    localparam logic [ADR_W-1:0] ADR_ACKSEL = 8'h08;
    localparam logic [ADR_W-1:0] ADR_STATUS = 8'h0c;

    typedef enum logic [2:0] {
        LIL_GREEN,
        LIL_RED,
        LIL_RED_FLASH,
        LIL_GREEN_FLASH,
        LIL_DARK
    } lil_colour_t;

    // ctrl word: [4:0] invert, [5] latch_en, [8:6] active, [11:9] inactive
    typedef struct packed {
        lil_colour_t inact;
        lil_colour_t act;
        logic latch_en;
        logic [NUM_IN-1:0] invert;
    } lil_ctrl_t;

    localparam int CTRL_W = $bits(lil_ctrl_t);

    // one source pick: used flag above a source index
    typedef struct packed {
        logic used;
        logic [IDX_W-1:0] idx;
    } lil_sel_t;

    localparam int PICK_W = $bits(lil_sel_t);
    localparam int ROUTE_W = NUM_IN * PICK_W;

    typedef struct packed {
        logic red;
        logic green;
        logic latched;
        logic or_state;
    } lil_status_t;

    localparam int STAT_W = $bits(lil_status_t);

    localparam lil_ctrl_t CTRL_RST = '{
        inact: LIL_DARK,
        act: LIL_RED,
        latch_en: 1'b0,
        invert: 5'h00
    };
    localparam lil_sel_t PICK_RST = '{used: 1'b0, idx: 4'h0};
    localparam logic [ROUTE_W-1:0] ROUTE_RST = 25'h0000000;

    // an unused pick contributes nothing unless its route slot is inverted
    function automatic logic lil_pick(input logic [SRC_W-1:0] src, input lil_sel_t s);
        lil_pick = s.used & src[s.idx];
    endfunction

    // byte-lane merge of a write into a stored word
    function automatic logic [DAT_W-1:0] lil_merge(
        input logic [DAT_W-1:0] old,
        input logic [DAT_W-1:0] wr,
        input logic [SEL_W-1:0] sel
    );
        logic [DAT_W-1:0] r;
        r = old;
        for (int b = 0; b < SEL_W; b++)
        begin
            if (sel[b])
            begin
                r[b*8 +: 8] = wr[b*8 +: 8];
            end
        end
        lil_merge = r;
    endfunction

    // {red, green} for a colour; flashing colours go dark in the off phase
    function automatic logic [1:0] lil_drive(input lil_colour_t c, input logic phase);
        case (c)
            LIL_GREEN: lil_drive = 2'h1;
            LIL_RED: lil_drive = 2'h2;
            LIL_RED_FLASH: lil_drive = phase ? 2'h2 : 2'h0;
            LIL_GREEN_FLASH: lil_drive = phase ? 2'h1 : 2'h0;
            default: lil_drive = 2'h0;
        endcase
    endfunction

endpackage

// *** lil_src_model.sv ***
// Purpose: stands in for the protection functions feeding the indicator
// Assumes: sources are levels in the clk_sys domain
// Notes: the led side is judged by the bench itself
`timescale 1ns/1ns
module lil_src_model (
    input wire logic clk_sys,
    output logic [lil_pkg::SRC_W-1:0] src_in
);
    initial src_in = '0;
    // change just after an edge so the block samples a settled level
    task automatic put(input logic [lil_pkg::SRC_W-1:0] v);
        @(posedge clk_sys);
        src_in <= v;
    endtask
endmodule

// *** test_led_indicator_logic.sv ***
// Purpose: self-checking bench for the indicator led block
// Assumes: ce dropped only in the hold scenario, blink half period cut to 4 cycles
// Notes: leds sampled three edges after each source change, except in the hold scenario where ce is dropped
`timescale 1ns/1ns
module test_led_indicator_logic;
    logic clk_sys = 1'b0, reset_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic ce = 1'b1;
    logic [7:0] wb_adr_i = '0;
    logic [3:0] wb_sel_i = '0;
    logic [31:0] wb_dat_i = '0, wb_dat_o, q;
    logic [15:0] src_in;
    logic wb_ack_o, led_red, led_green;
    int n_errors = 0, compares = 0;
    lil_src_model u_src (.clk_sys, .src_in);
    lil_indicator #(.BLINK_HALF_CYC(4)) u_dut (.clk_sys, .reset_n, .ce, .src_in,
        .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
        .wb_ack_o, .led_red, .led_green);
    initial
    begin
        forever #20 clk_sys = ~clk_sys;
    end
    task automatic results;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        n_errors += (got !== exp);
        if (got !== exp)
            $display("ERROR %0t got %h expected %h", $time, got, exp);
    endtask
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s);
        int i;
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        i = 0;
        do
        begin
            @(posedge clk_sys);
            i++;
        end
        while (wb_ack_o !== 1'b1 && i < 20);
        q = wb_dat_o;
        n_errors += (i >= 20);
        if (i >= 20)
            results;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'h0);
        chk(q, e);
    endtask
    task automatic lc(input logic [15:0] v, input logic [1:0] e);
        u_src.put(v);
        repeat (3) @(posedge clk_sys);
        chk({30'h0, led_red, led_green}, {30'h0, e});
    endtask
    task automatic s_reset;
        rc(8'h00, 32'h0000_0840);
        rc(8'h04, 32'h0);
        rc(8'h10, 32'h0);
        lc(16'h0, 2'h0);
    endtask
    task automatic s_or;
        bus(1'b1, 8'h04, 32'h01f0_0013, 4'hf);
        bus(1'b1, 8'h00, 32'h0000_0040, 4'hf);
        lc(16'h0000, 2'h1);
        lc(16'h0008, 2'h2);
        lc(16'h8000, 2'h2);
        lc(16'h0004, 2'h1);
        // only byte 0 may land
        bus(1'b1, 8'h00, 32'hffff_ff41, 4'h1);
        rc(8'h00, 32'h0000_0041);
        lc(16'h0000, 2'h2);
        lc(16'h0008, 2'h1);
    endtask
    task automatic s_flash;
        logic [31:0] nr, ng;
        bus(1'b1, 8'h04, 32'h0, 4'hf);
        for (int c = 0; c < 5; c++)
        begin
            bus(1'b1, 8'h00, c << 9, 4'hf);
            nr = '0;
            ng = '0;
            repeat (2) @(posedge clk_sys);
            // 16 samples span two whole blink periods whatever the phase
            repeat (16)
            begin
                @(posedge clk_sys);
                nr += led_red;
                ng += led_green;
            end
            chk(nr, c == 1 ? 16 : c == 2 ? 8 : 0);
            chk(ng, c == 0 ? 16 : c == 3 ? 8 : 0);
        end
    endtask
    task automatic s_latch;
        bus(1'b1, 8'h04, 32'h0000_0013, 4'hf);
        bus(1'b1, 8'h08, 32'h0000_0015, 4'hf);
        bus(1'b1, 8'h00, 32'h0000_0040, 4'hf);
        lc(16'h0008, 2'h2);
        lc(16'h0020, 2'h1);
        bus(1'b1, 8'h00, 32'h0000_0060, 4'hf);
        lc(16'h0008, 2'h2);
        lc(16'h0000, 2'h2);
        rc(8'h0c, 32'h0000_000a);
        lc(16'h0028, 2'h2);
        lc(16'h0000, 2'h2);
        lc(16'h0020, 2'h1);
        rc(8'h08, 32'h0000_0015);
    endtask
    task automatic s_hold;
        bus(1'b1, 8'h00, 32'h0000_0040, 4'hf);
        lc(16'h0008, 2'h2);
        @(posedge clk_sys);
        ce <= 1'b0;
        u_src.put(16'h0000);
        repeat (4) @(posedge clk_sys);
        chk({30'h0, led_red, led_green}, 32'h2);
        ce <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk({30'h0, led_red, led_green}, 32'h1);
    endtask
    initial
    begin
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        s_reset;
        s_or;
        s_flash;
        s_latch;
        s_hold;
        results;
    end
endmodule
